// ---- core/srp_port.sv ----
// Serial register access port: two-wire management slave
`timescale 1ns/1ns
`default_nettype none
module srp_port
   import srp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // Switch core read port
   input wire logic [SRP_ADDR_W-1:0] core_addr,
   output logic [SRP_REG_W-1:0] core_rdata,
   // Write notification to switch core
   output logic wr_pulse,
   output logic [SRP_ADDR_W-1:0] wr_addr,
   output logic [SRP_REG_W-1:0] wr_data
);
   // Synchronised pins
   logic [1:0] pins_s;
   logic mdc_s;
   logic mdio_s;
   logic mdc_d_q;
   logic rise;

   // Sequencer state
   srp_state_t state_q, state_d;
   logic [SRP_CNT_W-1:0] cnt_q, cnt_d;
   logic [SRP_ONES_W-1:0] ones_q, ones_d;
   logic [SRP_DATA_BITS-1:0] shift_q, shift_d;
   logic [SRP_DATA_BITS-1:0] tx_q, tx_d;
   logic [SRP_ADDR_W-1:0] addr_q, addr_d;
   logic rd_q, rd_d;
   logic out_q, out_d;
   logic oe_q, oe_d;
   logic wr_q, wr_d;
   logic [SRP_REG_W-1:0] wdat_q, wdat_d;

   // Helpers
   logic [SRP_ADDR_BITS-1:0] addr_full;
   logic [SRP_DATA_BITS-1:0] data_full;
   logic [SRP_REG_W-1:0] mem_rdata;
   logic [SRP_DATA_BITS-1:0] rd_word;

   srp_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_i({mdc, mdio_i}),
      .sync_o(pins_s)
   );

   assign mdc_s = pins_s[1];
   assign mdio_s = pins_s[0];

   // Rising management clock edge detect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mdc_d_q <= 1'b0;
      end else begin
         mdc_d_q <= mdc_s;
      end
   end

   assign rise = mdc_s & ~mdc_d_q;

   // Completed address and data fields including the bit now sampled
   assign addr_full = {shift_q[SRP_ADDR_BITS-2:0], mdio_s};
   assign data_full = {shift_q[SRP_DATA_BITS-2:0], mdio_s};
   assign rd_word = {SRP_UPPER_FILL, mem_rdata};

   srp_regmem #(
      .DEPTH(SRP_NUM_REGS)
   ) u_mem (
      .clk(clk),
      .wr_en(wr_q),
      .wr_addr(addr_q),
      .wr_data(wdat_q),
      .rd_addr(addr_q),
      .rd_data(mem_rdata),
      .core_addr(core_addr),
      .core_data(core_rdata)
   );

   // Frame sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      ones_d = ones_q;
      shift_d = shift_q;
      tx_d = tx_q;
      addr_d = addr_q;
      rd_d = rd_q;
      out_d = out_q;
      oe_d = oe_q;
      wr_d = 1'b0;
      wdat_d = wdat_q;
      if (rise) begin
         case (state_q)
            SRP_IDLE: begin
               oe_d = 1'b0;
               if (mdio_s) begin
                  if (ones_q < SRP_ONES_MIN) begin
                     ones_d = ones_q + 6'h01;
                  end
               end else begin
                  // First start bit after a full preamble
                  if (ones_q >= SRP_ONES_MIN) begin
                     state_d = SRP_START;
                  end
                  ones_d = '0;
               end
            end
            SRP_START: begin
               cnt_d = '0;
               if (mdio_s == SRP_START_SECOND) begin
                  state_d = SRP_OPCODE;
               end else begin
                  state_d = SRP_IDLE;
               end
            end
            SRP_OPCODE: begin
               shift_d = data_full;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == SRP_CNT_OP_END) begin
                  cnt_d = '0;
                  // Other opcodes are standard accesses, not ours
                  if (data_full[SRP_OP_BITS-1:0] == SRP_OPC_REG) begin
                     state_d = SRP_ADDR;
                  end else begin
                     state_d = SRP_IDLE;
                  end
               end
            end
            SRP_ADDR: begin
               shift_d = data_full;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == SRP_CNT_ADDR_END) begin
                  cnt_d = '0;
                  rd_d = addr_full[SRP_RD_BIT];
                  // Bit SRP_IGN_BIT is dropped here
                  addr_d = addr_full[SRP_REG_ADDR_MSB:0];
                  state_d = SRP_TURN;
               end
            end
            SRP_TURN: begin
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == '0) begin
                  // Controller released the line; drive zero next
                  if (rd_q) begin
                     oe_d = 1'b1;
                     out_d = SRP_TA_DRIVE;
                  end
               end
               if (cnt_q == SRP_CNT_TA_END) begin
                  cnt_d = '0;
                  state_d = SRP_DATA;
                  if (rd_q) begin
                     out_d = rd_word[SRP_DATA_BITS-1];
                     tx_d = {rd_word[SRP_DATA_BITS-2:0], 1'b0};
                  end
               end
            end
            SRP_DATA: begin
               cnt_d = cnt_q + 5'h01;
               shift_d = data_full;
               if (rd_q) begin
                  out_d = tx_q[SRP_DATA_BITS-1];
                  tx_d = {tx_q[SRP_DATA_BITS-2:0], 1'b0};
               end
               if (cnt_q == SRP_CNT_DATA_END) begin
                  cnt_d = '0;
                  oe_d = 1'b0;
                  state_d = SRP_IDLE;
                  // Out-of-map writes raise no notification either
                  if (!rd_q && (addr_q <= SRP_LAST_REG)) begin
                     wr_d = 1'b1;
                     wdat_d = data_full[SRP_REG_W-1:0];
                  end
               end
            end
            default: begin
               state_d = SRP_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // Frame sequencer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= SRP_IDLE;
         cnt_q <= '0;
         ones_q <= '0;
         shift_q <= '0;
         tx_q <= '0;
         addr_q <= '0;
         rd_q <= 1'b0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
         wr_q <= 1'b0;
         wdat_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ones_q <= ones_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         addr_q <= addr_d;
         rd_q <= rd_d;
         out_q <= out_d;
         oe_q <= oe_d;
         wr_q <= wr_d;
         wdat_q <= wdat_d;
      end
   end

   // Pin and core outputs
   assign mdio_o = out_q;
   assign mdio_oe = oe_q;
   assign wr_pulse = wr_q;
   assign wr_addr = addr_q;
   assign wr_data = wdat_q;

endmodule
`default_nettype wire

// ---- core/srp_pkg.sv ----
// Constants and types for the serial register access port
package srp_pkg;

   // Frame layout
   localparam int unsigned SRP_PRE_LEN = 32;
   localparam int unsigned SRP_OP_BITS = 2;
   localparam int unsigned SRP_ADDR_BITS = 10;
   localparam int unsigned SRP_TA_BITS = 2;
   localparam int unsigned SRP_DATA_BITS = 16;
   localparam logic [1:0] SRP_OPC_REG = 2'h0;
   localparam logic SRP_START_SECOND = 1'h1;
   localparam logic SRP_TA_DRIVE = 1'h0;

   // Field positions inside the ten address bits
   localparam int unsigned SRP_RD_BIT = 9;
   localparam int unsigned SRP_IGN_BIT = 8;
   localparam int unsigned SRP_REG_ADDR_MSB = 7;

   // Register map
   localparam int unsigned SRP_REG_W = 8;
   localparam int unsigned SRP_ADDR_W = 8;
   localparam int unsigned SRP_NUM_REGS = 142;
   localparam logic [7:0] SRP_LAST_REG = 8'h8d;
   localparam logic [7:0] SRP_UPPER_FILL = 8'h00;

   // Counter widths and end values
   localparam int unsigned SRP_CNT_W = 5;
   localparam int unsigned SRP_ONES_W = 6;
   localparam logic [4:0] SRP_CNT_OP_END = 5'h01;
   localparam logic [4:0] SRP_CNT_ADDR_END = 5'h09;
   localparam logic [4:0] SRP_CNT_TA_END = 5'h01;
   localparam logic [4:0] SRP_CNT_DATA_END = 5'h0f;
   localparam logic [5:0] SRP_ONES_MIN = 6'h20;

   // Frame sequencer states
   typedef enum logic [2:0] {
      SRP_IDLE = 3'b000,
      SRP_START = 3'b001,
      SRP_OPCODE = 3'b010,
      SRP_ADDR = 3'b011,
      SRP_TURN = 3'b100,
      SRP_DATA = 3'b101
   } srp_state_t;

endpackage

// ---- core/srp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module srp_sync #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous inputs and synchronised outputs
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

// ---- core/srp_regmem.sv ----
// Configuration register storage with registered read ports
`timescale 1ns/1ns
`default_nettype none
module srp_regmem
   import srp_pkg::*;
#(
   parameter int unsigned DEPTH = SRP_NUM_REGS
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic wr_en,
   input wire logic [SRP_ADDR_W-1:0] wr_addr,
   input wire logic [SRP_REG_W-1:0] wr_data,
   // Serial port read
   input wire logic [SRP_ADDR_W-1:0] rd_addr,
   output logic [SRP_REG_W-1:0] rd_data,
   // Switch core read
   input wire logic [SRP_ADDR_W-1:0] core_addr,
   output logic [SRP_REG_W-1:0] core_data
);
   logic [SRP_REG_W-1:0] mem_q [DEPTH];
   logic [SRP_REG_W-1:0] rd_q;
   logic [SRP_REG_W-1:0] core_q;

   // Out-of-map addresses write nothing and read zero
   always_ff @(posedge clk) begin
      if (wr_en && (wr_addr <= SRP_LAST_REG)) begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_q <= (rd_addr <= SRP_LAST_REG) ? mem_q[rd_addr] : '0;
      core_q <= (core_addr <= SRP_LAST_REG) ? mem_q[core_addr] : '0;
   end

   assign rd_data = rd_q;
   assign core_data = core_q;
endmodule
`default_nettype wire

// ---- dv/srp_port_monitor.sv ----
// Assertion checker for the serial register access port
`timescale 1ns/1ns
`default_nettype none
module srp_port_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_i,
   input wire logic mdio_o,
   input wire logic mdio_oe,
   // Core side
   input wire logic [7:0] core_addr,
   input wire logic [7:0] core_rdata,
   input wire logic wr_pulse,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] oe_cnt_q;
   logic [7:0] oe_cnt_d;
   // Cycles since drive began
   always_comb begin
      oe_cnt_d = mdio_oe ? oe_cnt_q + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oe_cnt_q <= 8'h00;
      end else begin
         oe_cnt_q <= oe_cnt_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_pulse_single: assert property (wr_pulse |=> !wr_pulse)
      else $error("write pulse too long");
   chk_write_no_drive: assert property (wr_pulse |-> !mdio_oe)
      else $error("drive during write");
   chk_addr_range: assert property (wr_pulse |-> wr_addr <= 8'h8d)
      else $error("write beyond last register");
   chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_o)
      else $error("turnaround bit not zero");
   chk_change_on_rise: assert property (($changed(mdio_o) || $changed(mdio_oe)) |-> $past(mdc, 3))
      else $error("data line changed away from clock rise");
   chk_oe_length: assert property ($fell(mdio_oe) |-> oe_cnt_q >= 8'd135 && oe_cnt_q <= 8'd137)
      else $error("drive span not seventeen bits");
   chk_upper_zero: assert property (mdio_oe && oe_cnt_q < 8'd70 |-> !mdio_o)
      else $error("upper read bits not zero");
   chk_reset_quiet: assert property (disable iff (1'b0) rst |-> !mdio_oe && !wr_pulse)
      else $error("outputs active in reset");
endmodule
bind srp_port srp_port_monitor srp_port_monitor_inst (.clk(clk), .rst(rst), .mdc(mdc),
   .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .core_addr(core_addr),
   .core_rdata(core_rdata), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));
`default_nettype wire

// ---- dv/srp_ctrl_model.sv ----
// Management controller model driving mdc and mdio
`timescale 1ns/1ns
`default_nettype none
module srp_ctrl_model (
   // Link to device
   output logic mdc,
   output logic mdio_i,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   logic c_oe = 1'b0;
   logic c_val = 1'b1;
   // Released line floats high through pull-up
   assign mdio_i = mdio_oe ? mdio_o : (c_oe ? c_val : 1'b1);
   initial mdc = 1'b0;
   task automatic bit_cyc(input logic drv, input logic v, output logic s);
      c_oe = drv;
      c_val = v;
      #160 mdc = 1'b1;
      s = mdio_i;
      #160 mdc = 1'b0;
   endtask
   task automatic frame(input int pre, input logic [1:0] op, input logic [9:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic t);
      logic s;
      logic rd;
      rd = a[9];
      for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
      bit_cyc(1'b1, 1'b0, s);
      bit_cyc(1'b1, 1'b1, s);
      for (int i = 1; i >= 0; i--) bit_cyc(1'b1, op[i], s);
      for (int i = 9; i >= 0; i--) bit_cyc(1'b1, a[i], s);
      bit_cyc(!rd, 1'b1, s);
      bit_cyc(!rd, 1'b0, t);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(!rd, d[i], s);
         q[i] = s;
      end
      c_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- dv/tb_srp_port.sv ----
// Self-checking bench for the serial register access port
`timescale 1ns/1ns
`default_nettype none
module tb_srp_port;
   logic clk = 1'b0;
   logic rst = 1'b0;
   logic [7:0] core_addr = 8'h00;
   wire logic mdc, mdio_i, mdio_o, mdio_oe, wr_pulse;
   wire logic [7:0] core_rdata, wr_addr, wr_data;
   int miscompares = 0;
   int check_count = 0;
   int pulses = 0;
   logic [7:0] pa;
   logic [7:0] pd;
   logic [15:0] q;
   logic t;
   always #20 clk = ~clk;
   srp_port srp_port_inst (.clk(clk), .rst(rst), .mdc(mdc), .mdio_i(mdio_i),
      .mdio_o(mdio_o), .mdio_oe(mdio_oe), .core_addr(core_addr), .core_rdata(core_rdata),
      .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));
   srp_ctrl_model srp_ctrl_model_inst (.mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe));
   always @(posedge clk) begin
      if (wr_pulse === 1'b1) begin
         pulses++;
         pa = wr_addr;
         pd = wr_data;
      end
   end
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_n(input int g, input int e);
      check_count++;
      if (g != e) begin
         miscompares++;
         $display("unexpected at %0t: count %0d want %0d", $time, g, e);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic t_wr_rd(input logic [7:0] r, input logic [7:0] v);
      int n;
      n = pulses;
      srp_ctrl_model_inst.frame(32, 2'b00, {2'b01, r}, {8'hff, v}, q, t);
      repeat (8) @(negedge clk);
      cmp_n(pulses, n + 1);
      cmp({pa, pd}, {r, v});
      core_addr = r;
      @(negedge clk);
      cmp(core_rdata, v);
      srp_ctrl_model_inst.frame(32, 2'b00, {2'b10, r}, 16'h0000, q, t);
      cmp(t, 1'b0);
      cmp(q, {8'h00, v});
   endtask
   task automatic t_refuse;
      int n;
      n = pulses;
      for (int op = 1; op < 4; op++) begin
         srp_ctrl_model_inst.frame(32, 2'(op), 10'h025, 16'hff00, q, t);
      end
      srp_ctrl_model_inst.frame(31, 2'b00, 10'h025, 16'hff00, q, t);
      srp_ctrl_model_inst.frame(32, 2'b00, 10'h08e, 16'h0077, q, t);
      repeat (8) @(negedge clk);
      cmp_n(pulses, n);
      srp_ctrl_model_inst.frame(32, 2'b00, 10'h225, 16'h0000, q, t);
      cmp(q, 16'h005a);
      srp_ctrl_model_inst.frame(32, 2'b00, 10'h28e, 16'h0000, q, t);
      cmp(q, 16'h0000);
   endtask
   initial begin
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_wr_rd(8'h00, 8'ha5);
      t_wr_rd(8'h25, 8'h5a);
      t_wr_rd(8'h8d, 8'h3c);
      t_refuse;
      stop_test;
   end
   initial begin
      #400000;
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
